// ===== logic/secure_region_pkg.sv
// Purpose: Shared constants and carriers for the secure region access block
// Assumes: Word-wide (16 bit) bus, 25 MHz system clock
// Notes: Array data itself lives outside; this block remaps and decodes
package secure_region_pkg;
  localparam int unsigned addr_w = 24;
  localparam int unsigned data_w = 16;
  localparam int unsigned region_words = 256;
  localparam logic [addr_w-1:0] region_last = 24'h0000ff;
  localparam logic [addr_w-1:0] factory_last = 24'h00007f;
  localparam logic [addr_w-1:0] customer_first = 24'h000080;
  localparam logic [addr_w-1:0] sector0_last = 24'h003fff;
  localparam logic [addr_w-1:0] bank0_last = 24'h01ffff;
  localparam logic [addr_w-1:0] ident_lock_addr = 24'h000003;
  localparam logic [addr_w-1:0] unlock_addr1 = 24'h000555;
  localparam logic [addr_w-1:0] unlock_addr2 = 24'h0002aa;
  localparam logic [data_w-1:0] unlock_data1 = 16'h00aa;
  localparam logic [data_w-1:0] unlock_data2 = 16'h0055;
  localparam logic [data_w-1:0] cmd_enter = 16'h0088;
  localparam logic [data_w-1:0] cmd_exit = 16'h0090;
  localparam logic [data_w-1:0] cmd_exit_final = 16'h0000;
  localparam logic [data_w-1:0] cmd_program = 16'h00a0;
  localparam logic [data_w-1:0] cmd_lock = 16'h0060;
  localparam int unsigned factory_lock_bit_pos = 7;
  localparam int unsigned customer_lock_bit_pos = 6;
  localparam logic [data_w-1:0] undefined_word = 16'hffff;
  localparam logic [data_w-1:0] blank_word = 16'hffff;
  localparam logic customer_lock_reset = 1'b0;
  localparam int unsigned clk_mhz = 25;
  localparam int unsigned async_access_time_ns = 80;
  localparam int unsigned sleep_extra_ns = 20;
  localparam int unsigned sleep_cycles = ((async_access_time_ns + sleep_extra_ns) * clk_mhz + 999) / 1000;
  localparam int unsigned reset_pulse_min_width_ns = 200;
  localparam int unsigned reset_cycles = (reset_pulse_min_width_ns * clk_mhz + 999) / 1000;
  localparam int unsigned program_time_ns = 40000;
  localparam int unsigned program_cycles = (program_time_ns * clk_mhz + 999) / 1000;
  typedef enum logic [6:0] {
    st_idle = 7'b0000001,
    st_u1 = 7'b0000010,
    st_u2 = 7'b0000100,
    st_exit4 = 7'b0001000,
    st_prog_data = 7'b0010000,
    st_busy = 7'b0100000,
    st_lock_data = 7'b1000000
  } cmd_state_e;
  typedef struct packed {
    logic [addr_w-1:0] addr;
    logic [data_w-1:0] data;
  } bus_word_s;
endpackage

// ===== logic/secure_word_store.sv
// Purpose: 256 word secure region storage, factory half fixed
// Assumes: Writes only reach the customer half
// Notes: Program clears bits only, like real cells
`timescale 1ns/1ns
module secure_word_store
  import secure_region_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Write side
  input wire logic wr_en,
  input wire logic [7:0] wr_index,
  input wire logic [data_w-1:0] wr_data,
  // Read side
  input wire logic [7:0] rd_index,
  output logic [data_w-1:0] rd_data
);
  logic [data_w-1:0] mem [region_words];
  wire wr_customer = wr_en && (wr_index[7] == 1'b1);
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < region_words; i++)
        mem[i] <= blank_word;
    end
    else if (wr_customer)
      mem[wr_index] <= mem[wr_index] & wr_data;
  end
  assign rd_data = mem[rd_index];
endmodule // secure_word_store

// ===== logic/secure_region_ctrl.sv
// Purpose: Command decode, sector 0 remap and power modes for the secure region
// Assumes: Host strobes are asynchronous; array data comes from outside
// Notes: Storage reset models a blank part, not power-loss behaviour
//
// Behaviour
// - Secure region is 256 words: factory 00-7F, customer 80-FF.
// - Async reads beyond the 256 word range return undefined data.
// - Identification address 03h shows factory lock flag on bit 7.
// - Customer lock flag on bit 6, zero when shipped unprotected.
// - Customer lock flag once set stays one forever.
// - Factory lock flag reads one; factory half never writable.
// - In secure mode bank 0 is blocked for other operations.
// - Power-up and reset leave secure mode, accesses go to array.
// - Secure reads served in both asynchronous and burst modes.
// - Burst reads in the region wrap from FFh to 00h.
// - Only sector 0 addresses remap; others return array data.
// - Secure access refused while embedded program or erase runs.
// - Customer half programs and locks once, never unlocks.
// - No accelerated or bypass programming of customer half; banks 1-15 readable.
// - Entry: AA at 555, 55 at 2AA, 88 at 555.
// - Exit: AA at 555, 55 at 2AA, 90 at 555, 00 anywhere.
// - Program: AA at 555, 55 at 2AA, A0 at 555, data at target.
// - Secure contents stay mapped until exit completes.
// - Reset aborts, floats outputs, clears config, ignores commands.
// - Output enable high floats the data outputs.
// - Deselect never aborts an operation; standby floats outputs.
// - Async reads sleep after stable access time plus 20 ns.
`timescale 1ns/1ns
module secure_region_ctrl
  import secure_region_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset,
  // Host pins, asynchronous
  input wire logic chip_enable_n,
  input wire logic output_enable_n,
  input wire logic write_enable_n,
  input wire logic reset_pin_n,
  input wire logic accelerated_program_input,
  input wire logic [addr_w-1:0] host_addr,
  input wire logic [data_w-1:0] host_wdata,
  // Read mode and burst
  input wire logic sync_mode,
  input wire logic burst_advance,
  // Array side
  input wire logic [data_w-1:0] array_rdata,
  input wire logic array_busy,
  output logic [addr_w-1:0] array_addr,
  // Data pins
  output logic [data_w-1:0] dq_out,
  output logic dq_oe_n,
  // Status
  output logic secure_mode,
  output logic bank0_blocked,
  output logic sleeping,
  output logic config_clear,
  output logic program_busy
);
  // Three stage sync; stage 1 feeds only stage 2
  logic [2:0] ce_s, oe_s, we_s, rst_s, acc_s;
  logic ce_n, oe_n, we_n, rst_n_q, acc_n;
  bus_word_s bus_s1, bus_s2, bus_s3, bus_q;
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ce_s <= 3'h7;
      oe_s <= 3'h7;
      we_s <= 3'h7;
      rst_s <= 3'h7;
      acc_s <= 3'h7;
      bus_s1 <= '0;
      bus_s2 <= '0;
      bus_s3 <= '0;
    end
    else
    begin
      ce_s <= {ce_s[1:0], chip_enable_n};
      oe_s <= {oe_s[1:0], output_enable_n};
      we_s <= {we_s[1:0], write_enable_n};
      rst_s <= {rst_s[1:0], reset_pin_n};
      acc_s <= {acc_s[1:0], accelerated_program_input};
      bus_s1 <= '{addr: host_addr, data: host_wdata};
      bus_s2 <= bus_s1;
      bus_s3 <= bus_s2;
    end
  end
  function automatic logic agree(input logic [2:0] s, input logic prev);
    return (s[1] == s[2]) ? s[2] : prev;
  endfunction
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      ce_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      rst_n_q <= 1'b1;
      acc_n <= 1'b1;
      bus_q <= '0;
    end
    else
    begin
      ce_n <= agree(ce_s, ce_n);
      oe_n <= agree(oe_s, oe_n);
      we_n <= agree(we_s, we_n);
      rst_n_q <= agree(rst_s, rst_n_q);
      acc_n <= agree(acc_s, acc_n);
      if (bus_s2 == bus_s3)
        bus_q <= bus_s3;
    end
  end
  // Reset pin pulse width counter
  logic [7:0] rst_cnt;
  wire pin_reset = !rst_n_q && (rst_cnt >= 8'(reset_cycles - 1));
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      rst_cnt <= 8'h0;
    else if (rst_n_q)
      rst_cnt <= 8'h0;
    else if (rst_cnt != 8'hff)
      rst_cnt <= rst_cnt + 8'h1;
  end
  // Write taken on the rising edge of the write strobe
  logic we_prev;
  wire write_strobe = !we_prev && we_n && !ce_n && rst_n_q;
  wire [addr_w-1:0] wa = bus_q.addr;
  wire [data_w-1:0] wd = bus_q.data;
  wire in_sector0 = (bus_q.addr <= sector0_last);
  // Command decoder
  cmd_state_e state, next_state;
  logic mode_sec, next_mode_sec;
  logic cust_lock;
  logic after_a0;
  logic [17:0] busy_cnt;
  logic [7:0] prog_index;
  logic [data_w-1:0] prog_data;
  wire u1_ok = (wa == unlock_addr1) && (wd == unlock_data1);
  wire u2_ok = (wa == unlock_addr2) && (wd == unlock_data2);
  wire at_555 = (wa == unlock_addr1);
  wire prog_allowed = mode_sec && !cust_lock && acc_n;
  wire prog_word_ok = in_sector0 && (wa <= region_last) && (wa >= customer_first);
  wire prog_start = (state == st_prog_data) && write_strobe && prog_word_ok;
  wire lock_start = (state == st_lock_data) && write_strobe;
  always_comb
  begin
    next_state = state;
    next_mode_sec = mode_sec;
    unique case (state)
      st_idle:
        if (write_strobe && u1_ok)
          next_state = st_u1;
      st_u1:
        if (write_strobe)
          next_state = u2_ok ? st_u2 : st_idle;
      st_u2:
        if (write_strobe)
        begin
          next_state = st_idle;
          if (at_555 && wd == cmd_enter && !array_busy)
            next_mode_sec = 1'b1;
          else if (at_555 && wd == cmd_exit && mode_sec)
            next_state = st_exit4;
          else if (at_555 && wd == cmd_program && prog_allowed)
            next_state = st_prog_data;
          else if (at_555 && wd == cmd_lock && prog_allowed)
            next_state = st_lock_data;
        end
      st_exit4:
        if (write_strobe)
        begin
          next_state = st_idle;
          if (wd == cmd_exit_final)
            next_mode_sec = 1'b0;
        end
      st_prog_data:
        if (write_strobe)
          next_state = prog_word_ok ? st_busy : st_idle;
      st_lock_data:
        if (write_strobe)
          next_state = st_busy;
      st_busy:
        if (busy_cnt == 18'h0)
          next_state = st_idle;
      default:
        next_state = st_idle;
    endcase
  end
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      state <= st_idle;
      mode_sec <= 1'b0;
      we_prev <= 1'b1;
    end
    else if (pin_reset)
    begin
      state <= st_idle;
      mode_sec <= 1'b0;
      we_prev <= we_n;
    end
    else
    begin
      state <= next_state;
      mode_sec <= next_mode_sec;
      we_prev <= we_n;
    end
  end
  // Program timer and latched request; chip select does not stop it
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      busy_cnt <= 18'h0;
      prog_index <= 8'h0;
      prog_data <= '0;
      after_a0 <= 1'b0;
    end
    else if (prog_start || lock_start)
    begin
      busy_cnt <= 18'(program_cycles - 1);
      prog_index <= wa[7:0];
      prog_data <= wd;
      after_a0 <= prog_start;
    end
    else if (busy_cnt != 18'h0 && !pin_reset)
      busy_cnt <= busy_cnt - 18'h1;
    else
      busy_cnt <= 18'h0;
  end
  wire prog_done = (state == st_busy) && (busy_cnt == 18'h0) && !pin_reset;
  // Lock flag only ever sets
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      cust_lock <= customer_lock_reset;
    else if (prog_done && !after_a0)
      cust_lock <= 1'b1;
  end
  // Storage and burst address
  logic [7:0] burst_idx;
  wire [7:0] rd_index = sync_mode ? burst_idx : bus_q.addr[7:0];
  logic [data_w-1:0] store_rdata;
  secure_word_store u_store (
    .clk_sys(clk_sys),
    .reset(reset),
    .wr_en(prog_done && after_a0),
    .wr_index(prog_index),
    .wr_data(prog_data),
    .rd_index(rd_index),
    .rd_data(store_rdata)
  );
  logic [addr_w-1:0] addr_prev;
  wire addr_change = (bus_q.addr != addr_prev);
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      burst_idx <= 8'h0;
    else if (addr_change)
      burst_idx <= bus_q.addr[7:0];
    else if (sync_mode && burst_advance)
      burst_idx <= burst_idx + 8'h1;
  end
  // Read path selection
  wire sec_hit = mode_sec && in_sector0 && !array_busy;
  wire beyond = sync_mode ? 1'b0 : (bus_q.addr > region_last);
  wire [data_w-1:0] lock_word = (data_w'(1) << factory_lock_bit_pos)
                              | (data_w'(cust_lock) << customer_lock_bit_pos);
  wire ident_read = (state == st_idle) && !mode_sec && (bus_q.addr == ident_lock_addr) && !ce_n && we_n && !oe_n;
  wire [data_w-1:0] sec_word = beyond ? undefined_word : store_rdata;
  wire [data_w-1:0] next_dq = sec_hit ? sec_word : array_rdata;
  wire drive = !ce_n && !oe_n && rst_n_q;
  // Automatic sleep timer
  logic [3:0] stable_cnt;
  wire sleep_now = !sync_mode && (stable_cnt >= 4'(sleep_cycles));
  // Writes and busy time wake it, so a latch never hides changed contents
  wire sleep_wake = addr_change || sync_mode || write_strobe || (state != st_idle);
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      stable_cnt <= 4'h0;
      addr_prev <= '0;
    end
    else
    begin
      addr_prev <= bus_q.addr;
      if (sleep_wake)
        stable_cnt <= 4'h0;
      else if (!sleep_now)
        stable_cnt <= stable_cnt + 4'h1;
    end
  end
  logic ident_seen;
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      dq_out <= '0;
      dq_oe_n <= 1'b1;
      secure_mode <= 1'b0;
      bank0_blocked <= 1'b0;
      sleeping <= 1'b0;
      config_clear <= 1'b0;
      program_busy <= 1'b0;
      array_addr <= '0;
      ident_seen <= 1'b0;
    end
    else
    begin
      ident_seen <= ident_read;
      if (!sleep_now || !sleeping)
        dq_out <= ident_seen ? lock_word : next_dq;
      dq_oe_n <= !drive;
      secure_mode <= mode_sec;
      bank0_blocked <= mode_sec;
      sleeping <= sleep_now;
      config_clear <= pin_reset;
      program_busy <= (state == st_busy);
      array_addr <= bus_q.addr;
    end
  end
endmodule // secure_region_ctrl

// ===== bench/array_model.sv
// Purpose: Stand-in for the normal array behind the block
// Assumes: One cycle read latency
// Notes: Word pattern comes from the address, so a wrong remap shows up
`timescale 1ns/1ns
module array_model
  import secure_region_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Array port
  input wire logic [addr_w-1:0] array_addr,
  output logic [data_w-1:0] array_rdata
);
  always_ff @(posedge clk_sys)
    array_rdata <= {array_addr[7:0], ~array_addr[7:0]};
endmodule // array_model

// ===== bench/secure_region_ctrl_assertions.sv
// Purpose: Port-level checks for the secure region controller
// Assumes: Host pins pass a 3-4 cycle synchroniser
// Notes: Windows carry slack for that synchroniser
`timescale 1ns/1ns
module secure_region_ctrl_assertions
  import secure_region_pkg::*;
(
  // Clock and reset
  input logic clk_sys,
  input logic reset,
  // Host pins, read mode and array busy
  input logic chip_enable_n,
  input logic output_enable_n,
  input logic reset_pin_n,
  input logic accelerated_program_input,
  input logic sync_mode,
  input logic array_busy,
  // Outputs watched
  input logic [data_w-1:0] dq_out,
  input logic dq_oe_n,
  input logic secure_mode,
  input logic bank0_blocked,
  input logic sleeping,
  input logic config_clear,
  input logic program_busy
);
  int unsigned low_cnt;
  int unsigned busy_cnt;
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      low_cnt <= 0;
      busy_cnt <= 0;
    end
    else
    begin
      low_cnt <= reset_pin_n ? 0 : low_cnt + 1;
      busy_cnt <= program_busy ? busy_cnt + 1 : 0;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_bank_block_mirror: assert property (bank0_blocked == secure_mode) else $error("bank block differs");
  a_pin_reset_clears: assert property (low_cnt >= 12 |-> !secure_mode && config_clear && !program_busy && dq_oe_n)
    else $error("pin reset left state");
  a_oe_high_float: assert property (output_enable_n [*8] |-> dq_oe_n) else $error("driving with oe high");
  a_standby_float: assert property (chip_enable_n [*8] |-> dq_oe_n) else $error("driving in standby");
  a_no_enter_busy: assert property (array_busy [*8] |-> !$rose(secure_mode)) else $error("entered while busy");
  a_sync_no_sleep: assert property (sync_mode [*8] |-> !sleeping) else $error("sleep in sync mode");
  a_sleep_holds_data: assert property (sleeping && $past(sleeping) |-> $stable(dq_out)) else $error("data moved");
  a_acc_low_refuse: assert property (!accelerated_program_input [*8] |-> !$rose(program_busy))
    else $error("program with acc low");
  a_program_min_len: assert property ($rose(program_busy) |-> program_busy [*8]) else $error("program too short");
  a_program_max_len: assert property (busy_cnt <= program_cycles + 8) else $error("program too long");
  // Main scenarios reached
  cover property ($rose(secure_mode));
  cover property ($fell(secure_mode));
  cover property ($rose(program_busy));
  cover property ($rose(sleeping));
endmodule // secure_region_ctrl_assertions
bind secure_region_ctrl secure_region_ctrl_assertions chk_i (.clk_sys, .reset, .chip_enable_n, .output_enable_n,
  .reset_pin_n, .accelerated_program_input, .sync_mode, .array_busy, .dq_out, .dq_oe_n, .secure_mode,
  .bank0_blocked, .sleeping, .config_clear, .program_busy);

// ===== bench/secure_region_access_power_modes_tb.sv
// Purpose: Self-checking bench for the secure region controller
// Assumes: Strobes held long enough for the synchroniser
// Notes: Burst advance walks the index through the wrap
`timescale 1ns/1ns
module secure_region_access_power_modes_tb;
  import secure_region_pkg::*;
  logic clk_sys = 1'h0, reset = 1'h1, ce_n = 1'h1, oe_n = 1'h1, we_n = 1'h1, pin_n = 1'h1, acc = 1'h1;
  logic sync_mode = 1'h0, busy = 1'h0, advance = 1'h0;
  logic [23:0] addr = 24'h0, array_addr;
  logic [15:0] wdata = 16'h0, dq_out, array_rdata;
  logic dq_oe_n, secure_mode, bank0_blocked, sleeping, config_clear, program_busy;
  logic [23:0] ra [4] = '{24'h000080, 24'h000100, 24'h004012, 24'h020034};
  logic [15:0] re [4] = '{16'hffff, 16'hffff, 16'h12ed, 16'h34cb};
  int errors = 0, checks = 0;
  always #20 clk_sys = ~clk_sys;
  array_model am (.clk_sys, .array_addr, .array_rdata);
  secure_region_ctrl dut (.clk_sys, .reset, .chip_enable_n(ce_n), .output_enable_n(oe_n), .write_enable_n(we_n),
    .reset_pin_n(pin_n), .accelerated_program_input(acc), .host_addr(addr), .host_wdata(wdata), .sync_mode,
    .burst_advance(advance), .array_rdata, .array_busy(busy), .array_addr, .dq_out, .dq_oe_n, .secure_mode,
    .bank0_blocked, .sleeping, .config_clear, .program_busy);
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic report_and_stop;
    if (errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    ce_n <= 1'h0;
    cyc(1);
    we_n <= 1'h0;
    cyc(6);
    we_n <= 1'h1;
    cyc(6);
    ce_n <= 1'h1;
    cyc(2);
  endtask
  task automatic cmd(input logic [15:0] c);
    wr(unlock_addr1, unlock_data1);
    wr(unlock_addr2, unlock_data2);
    wr(unlock_addr1, c);
  endtask
  // A timer that never ends counts as a mismatch
  task automatic wait_idle;
    for (int i = 0; i < 1200 && program_busy !== 1'h0; i++)
      cyc(1);
    if (program_busy !== 1'h0)
      errors++;
  endtask
  task automatic prog(input logic [23:0] a, input logic [15:0] d);
    cmd(cmd_program);
    wr(a, d);
    wait_idle();
  endtask
  task automatic rd(input logic [23:0] a, input logic [15:0] e, input logic [15:0] m = 16'hffff);
    addr <= a;
    ce_n <= 1'h0;
    oe_n <= 1'h0;
    cyc(10);
    chk(dq_out & m, e & m);
    chk(dq_oe_n, 16'h0);
    oe_n <= 1'h1;
    ce_n <= 1'h1;
    cyc(2);
  endtask
  // Generous: the programs dominate, near 3000 cycles
  initial
  begin
    cyc(20000);
    errors++;
    report_and_stop();
  end
  initial
  begin
    cyc(20);
    reset <= 1'h0;
    cyc(2);
    rd(24'h000010, 16'h10ef);
    chk(sleeping, 16'h1);
    rd(ident_lock_addr, 16'h0080, 16'h00c0);
    busy <= 1'h1;
    cmd(cmd_enter);
    chk(secure_mode, 16'h0);
    busy <= 1'h0;
    cmd(cmd_enter);
    chk(secure_mode, 16'h1);
    chk(bank0_blocked, 16'h1);
    for (int i = 0; i < 4; i++)
      rd(ra[i], re[i]);
    prog(24'h000085, 16'h1234);
    rd(24'h000085, 16'h1234);
    prog(24'h000005, 16'h0000);
    rd(24'h000005, blank_word);
    acc <= 1'h0;
    prog(24'h000086, 16'h0000);
    acc <= 1'h1;
    rd(24'h000086, blank_word);
    cmd(16'h0077);
    wr(24'h000000, cmd_exit_final);
    chk(secure_mode, 16'h1);
    cmd(cmd_program);
    wr(24'h000088, 16'h0000);
    ce_n <= 1'h0;
    oe_n <= 1'h0;
    pin_n <= 1'h0;
    cyc(15);
    chk(program_busy, 16'h0);
    chk(config_clear, 16'h1);
    chk(dq_oe_n, 16'h1);
    pin_n <= 1'h1;
    oe_n <= 1'h1;
    ce_n <= 1'h1;
    cyc(8);
    chk(secure_mode, 16'h0);
    cmd(cmd_enter);
    cmd(cmd_lock);
    wr(24'h000000, 16'h0000);
    wait_idle();
    prog(24'h000087, 16'h0000);
    rd(24'h000087, blank_word);
    sync_mode <= 1'h1;
    rd(24'h000085, 16'h1234);
    // From FFh, 86h steps land on 85h only if the index wraps
    addr <= 24'h0000ff;
    ce_n <= 1'h0;
    oe_n <= 1'h0;
    cyc(10);
    advance <= 1'h1;
    cyc(134);
    advance <= 1'h0;
    cyc(4);
    chk(dq_out, 16'h1234);
    oe_n <= 1'h1;
    ce_n <= 1'h1;
    cyc(2);
    sync_mode <= 1'h0;
    cmd(cmd_exit);
    wr(24'h000000, cmd_exit_final);
    chk(secure_mode, 16'h0);
    rd(ident_lock_addr, 16'h00c0, 16'h00c0);
    rd(24'h000085, 16'h857a);
    report_and_stop();
  end
endmodule // secure_region_access_power_modes_tb
